// >>> verilog/swk_cdr_decoder.sv
// Recovery setup, silence timeout and FD-tolerant frame tracking
//
// Behaviour
// RULE_01 - Host sets mode off and recovery disabled before changing setup.
// RULE_02 - Host then programs the two-bit input clock select.
// RULE_03 - Host then programs time quanta per bit and both limits.
// RULE_04 - Host finally sets filter options and writes recovery enable.
// RULE_05 - At a limit, drop acquired timing and reload time quanta value.
// RULE_06 - Host updates clock select, quanta and limits on rate change.
// RULE_07 - Host disables recovery while rewriting its settings.
// RULE_08 - Sample point register defaults to code 11 0011, about 80%.
// RULE_09 - Bus counts as inactive after 0.6 to 1.2 s without activity.
// RULE_10 - Wake is signalled within 100 us of pattern or frame end.
// RULE_11 - Decoder supports bit times down to 1 us, 1 Mbit/s.
// RULE_12 - FD mode needs six to ten recessive idle bits before SOF.
// RULE_13 - Dominant glitches shorter than filter fraction are ignored.
// RULE_14 - Long enough dominant pulses after FDF count as data bits.
// RULE_15 - FD tolerance holds to 500 kbps and receiver select clear.
// RULE_16 - Filter class limits data rate to 4x/2M or 10x/5M.
// RULE_17 - FD mode skips frames with FDF set until their end of frame.
// RULE_18 - Silence timeout expiry clears the error-counter-disable bit.
// RULE_19 - New recovery setup takes effect only while recovery is off.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "swk_cfg.svh"

module swk_cdr_decoder #(
  parameter int SilenceMs = `SWK_SILENCE_MIN_MS,
  parameter int SilenceCycles = `SWK_CLK_HZ / 1000 * SilenceMs
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // CAN receive pin
  input wire logic canRx,
  // Frame decoder events from the protocol logic
  input wire logic frameFdf,
  input wire logic wakeDetect,
  // Outputs
  output logic busSilent,
  output logic wakeOut,
  output logic [7:0] recoveredTq,
  output logic [2:0] transceiverMode,
  output logic irqOut
);
  import swk_pkg::*;

  // ------------------------------------------------------------
  // Reset and pin synchronisers
  // ------------------------------------------------------------
  logic rstMeta_q, rstSync_q;
  logic rxMeta_q, rxSync_q, rxPrev_q;
  wire rstnInt = rstSync_q;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Bus pin into clock domain, recessive is high
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= canRx;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end
  wire rxEdge = rxSync_q ^ rxPrev_q;
  wire rxDom = !rxSync_q;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [2:0] mode_q;
  logic recEn_q;
  logic [1:0] clkSel_q;
  logic [7:0] tq_q, limHi_q, limLo_q;
  logic [5:0] spp_q;
  logic [3:0] filtCtl_q;
  logic fdEn_q, rxSel_q, errDis_q;
  logic [2:0] fdFilt_q;
  logic [3:0] irqSt_q, irqMsk_q;
  logic [31:0] rdData_q;
  logic rdDone_q;
  swk_state_t state_q;
  logic fdfSkip;

  wire [3:0] regIdx = address[5:2];
  wire wrAcc = write && (address[1:0] == 2'b00);
  wire rdAcc = read && !rdDone_q;
  // Setup registers writable only while recovery is disabled
  wire setupOk = !recEn_q; // [RULE_19]
  wire wrMode = wrAcc && regIdx == `SWK_ADDR_MODE;
  wire wrClk = wrAcc && regIdx == `SWK_ADDR_CLKSEL && setupOk; // [RULE_19]
  wire wrTq = wrAcc && regIdx == `SWK_ADDR_TQ && setupOk;
  wire wrSpp = wrAcc && regIdx == `SWK_ADDR_SPP && setupOk;
  wire wrHi = wrAcc && regIdx == `SWK_ADDR_LIMHI && setupOk;
  wire wrLo = wrAcc && regIdx == `SWK_ADDR_LIMLO && setupOk;
  wire wrFilt = wrAcc && regIdx == `SWK_ADDR_FILT;
  wire wrFd = wrAcc && regIdx == `SWK_ADDR_FDCTL;
  wire wrMsk = wrAcc && regIdx == `SWK_ADDR_IRQMSK;
  wire rdIrq = rdAcc && regIdx == `SWK_ADDR_IRQST;

  // Events
  logic silenceHit, limitHit, fdfSeen, wakeHit;
  wire [3:0] events = {fdfSeen, limitHit, wakeHit, silenceHit};

  // Read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (regIdx)
      `SWK_ADDR_MODE: rdMux = {28'h0, recEn_q, mode_q};
      `SWK_ADDR_CLKSEL: rdMux = {30'h0, clkSel_q};
      `SWK_ADDR_TQ: rdMux = {24'h0, tq_q};
      `SWK_ADDR_SPP: rdMux = {26'h0, spp_q};
      `SWK_ADDR_LIMHI: rdMux = {24'h0, limHi_q};
      `SWK_ADDR_LIMLO: rdMux = {24'h0, limLo_q};
      `SWK_ADDR_FILT: rdMux = {28'h0, filtCtl_q};
      `SWK_ADDR_FDCTL: rdMux = {26'h0, fdFilt_q, errDis_q, rxSel_q, fdEn_q};
      `SWK_ADDR_STAT: rdMux = {29'h0, fdfSkip, wakeOut, busSilent};
      `SWK_ADDR_IRQST: rdMux = {28'h0, irqSt_q};
      `SWK_ADDR_IRQMSK: rdMux = {28'h0, irqMsk_q};
      `SWK_ADDR_TQCUR: rdMux = {24'h0, recoveredTq};
      default: rdMux = 32'h0;
    endcase
  end

  // Configuration registers; setup sequence is kept by the host
  always_ff @(posedge clk_sys or negedge rstnInt) begin // [RULE_01]
    if (!rstnInt) begin
      mode_q <= `SWK_MODE_OFF;
      recEn_q <= 1'b0;
      clkSel_q <= `SWK_RST_CLKSEL;
      tq_q <= `SWK_RST_TQ;
      spp_q <= `SWK_RST_SPP; // [RULE_08]
      limHi_q <= `SWK_RST_LIMHI;
      limLo_q <= `SWK_RST_LIMLO;
      filtCtl_q <= 4'h0;
      irqMsk_q <= 4'h0;
    end else begin
      if (wrMode) begin
        mode_q <= writedata[2:0];
        recEn_q <= writedata[3]; // [RULE_04]
      end
      if (wrClk) clkSel_q <= writedata[1:0]; // [RULE_02]
      if (wrTq) tq_q <= writedata[7:0]; // [RULE_03]
      if (wrSpp) spp_q <= writedata[5:0];
      if (wrHi) limHi_q <= writedata[7:0];
      if (wrLo) limLo_q <= writedata[7:0];
      if (wrFilt) filtCtl_q <= writedata[3:0];
      if (wrMsk) irqMsk_q <= writedata[3:0];
    end
  end

  // FD control; silence expiry clears error-counter disable
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      fdEn_q <= 1'b0;
      rxSel_q <= 1'b0;
      errDis_q <= 1'b0;
      fdFilt_q <= 3'h0;
    end else begin
      if (wrFd) begin
        fdEn_q <= writedata[`SWK_FD_EN_BIT];
        rxSel_q <= writedata[`SWK_FD_RXSEL_BIT];
        fdFilt_q <= writedata[`SWK_FD_FILT_BIT+2:`SWK_FD_FILT_BIT];
      end
      if (silenceHit) errDis_q <= 1'b0; // [RULE_18]
      else if (wrFd) errDis_q <= writedata[`SWK_FD_ERRDIS_BIT];
    end
  end

  // Sticky interrupt status, cleared by read; new event wins
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) irqSt_q <= 4'h0;
    else irqSt_q <= (rdIrq ? 4'h0 : irqSt_q) | events;
  end

  // Bus answer: one wait cycle on reads, writes immediate
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      rdDone_q <= 1'b0;
      rdData_q <= 32'h0;
      irqOut <= 1'b0;
    end else begin
      rdDone_q <= rdAcc;
      if (rdAcc) rdData_q <= rdMux;
      irqOut <= |(((rdIrq ? 4'h0 : irqSt_q) | events) & irqMsk_q);
    end
  end
  assign readdata = rdData_q;
  assign waitrequest = read && !rdDone_q;
  assign transceiverMode = mode_q;

  // ------------------------------------------------------------
  // Silence timeout
  // ------------------------------------------------------------
  logic [31:0] silCnt_q;
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      silCnt_q <= 32'h0;
      busSilent <= 1'b0;
    end else if (rxEdge || rxDom) begin
      silCnt_q <= 32'h0;
      busSilent <= 1'b0;
    end else if (silCnt_q < SilenceCycles[31:0]) begin
      silCnt_q <= silCnt_q + 32'h1;
    end else begin
      busSilent <= 1'b1; // [RULE_09]
    end
  end
  assign silenceHit = !busSilent && !rxEdge && !rxDom &&
                      silCnt_q >= SilenceCycles[31:0];

  // ------------------------------------------------------------
  // Clock recovery: bit length tracking within limits
  // ------------------------------------------------------------
  logic [7:0] tqCur_q, runLen_q, quCnt_q;
  wire quTick = quCnt_q == `SWK_SYS_PER_TQ - 8'h1;
  wire outOfLim = runLen_q > limHi_q || runLen_q < limLo_q;
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      quCnt_q <= 8'h0;
      runLen_q <= 8'h0;
      tqCur_q <= `SWK_RST_TQ;
    end else begin
      quCnt_q <= quTick ? 8'h0 : quCnt_q + 8'h1; // [RULE_11]
      if (!recEn_q) tqCur_q <= tq_q; // [RULE_19]
      else if (rxEdge && runLen_q != 8'h0) begin
        if (outOfLim) tqCur_q <= tq_q; // [RULE_05]
        else tqCur_q <= runLen_q;
      end
      if (rxEdge) runLen_q <= 8'h0;
      else if (quTick && runLen_q != 8'hff) runLen_q <= runLen_q + 8'h1;
    end
  end
  assign limitHit = recEn_q && rxEdge && runLen_q != 8'h0 && outOfLim;
  assign recoveredTq = tqCur_q;

  // ------------------------------------------------------------
  // FD tolerant tracking: glitch filter, FDF skip, idle count
  // ------------------------------------------------------------
  logic [7:0] domLen_q;
  logic [7:0] tqBit_q;
  logic [3:0] idleBits_q;
  logic wake_q;
  assign fdfSkip = state_q == SWK_SKIP;
  // Glitch threshold in quanta from filter code
  wire [7:0] glitchLim = {5'h0, fdFilt_q};
  wire domValid = rxDom && domLen_q > glitchLim; // [RULE_13] [RULE_14]
  wire bitTick = quTick && tqBit_q == tqCur_q - 8'h1;
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      domLen_q <= 8'h0;
      tqBit_q <= 8'h0;
    end else begin
      if (!rxDom) domLen_q <= 8'h0;
      else if (quTick && domLen_q != 8'hff) domLen_q <= domLen_q + 8'h1;
      if (rxEdge || bitTick) tqBit_q <= 8'h0;
      else if (quTick) tqBit_q <= tqBit_q + 8'h1;
    end
  end

  // Frame state: idle needs recessive run before new SOF
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      state_q <= SWK_IDLE;
      idleBits_q <= 4'h0;
    end else begin
      if (domValid) idleBits_q <= 4'h0;
      else if (bitTick && idleBits_q != 4'hf) idleBits_q <= idleBits_q + 4'h1;
      case (state_q)
        SWK_IDLE: begin
          if (domValid && idleBits_q >= `SWK_IDLE_BITS) // [RULE_12]
            state_q <= SWK_FRAME;
        end
        SWK_FRAME: begin
          if (fdEn_q && frameFdf) state_q <= SWK_SKIP; // [RULE_17]
          else if (idleBits_q >= `SWK_IDLE_BITS) state_q <= SWK_IDLE;
        end
        SWK_SKIP: begin
          if (idleBits_q >= `SWK_IDLE_BITS) state_q <= SWK_IDLE; // [RULE_17]
        end
        default: state_q <= SWK_IDLE;
      endcase
    end
  end
  assign fdfSeen = state_q == SWK_FRAME && fdEn_q && frameFdf;

  // Wake: registered one cycle after detection, far inside 100 us
  assign wakeHit = wakeDetect && !fdfSkip;
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) wake_q <= 1'b0;
    else wake_q <= wakeHit; // [RULE_10]
  end
  assign wakeOut = wake_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_silence_clear: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    silenceHit |=> !errDis_q) else $error("error disable kept"); // [RULE_18]
  a_limit_reload: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    limitHit |=> tqCur_q == $past(tq_q)) else $error("no reload"); // [RULE_05]
  a_cfg_locked: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    recEn_q && $past(recEn_q) |-> $stable(tq_q)) else $error("tq changed"); // [RULE_19]
  a_wake_time: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    wakeHit |-> ##[1:4] wakeOut) else $error("wake late"); // [RULE_10]
  a_skip_fdf: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    fdfSeen |=> fdfSkip) else $error("fdf not skipped"); // [RULE_17]
  a_no_wake_skip: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    fdfSkip |=> !wakeOut) else $error("wake on fd frame"); // [RULE_17]
  a_sof_idle: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    state_q == SWK_IDLE ##1 state_q == SWK_FRAME |->
    $past(idleBits_q) >= `SWK_IDLE_BITS) else $error("early sof"); // [RULE_12]
  a_glitch_drop: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    rxDom && domLen_q <= glitchLim |-> !domValid) else $error("glitch"); // [RULE_13]
  a_spp_reset: assert property (@(posedge clk_sys) disable iff (!rstnInt)
    $rose(rstnInt) |-> spp_q == `SWK_RST_SPP) else $error("spp"); // [RULE_08]
  c_wake: cover property (@(posedge clk_sys) disable iff (!rstnInt) wakeOut);
  c_skip: cover property (@(posedge clk_sys) disable iff (!rstnInt) fdfSkip);
  c_limit: cover property (@(posedge clk_sys) disable iff (!rstnInt) limitHit);
  c_silent: cover property (@(posedge clk_sys) disable iff (!rstnInt) silenceHit);
endmodule

// >>> verilog/swk_cfg.svh
// Constants for the selective-wake recovery and FD-tolerant decoder
`ifndef SWK_CFG_SVH
`define SWK_CFG_SVH
// Register word indices (address bits 5:2, byte address is index times four)
`define SWK_ADDR_MODE 4'h0
`define SWK_ADDR_CLKSEL 4'h1
`define SWK_ADDR_TQ 4'h2
`define SWK_ADDR_SPP 4'h3
`define SWK_ADDR_LIMHI 4'h4
`define SWK_ADDR_LIMLO 4'h5
`define SWK_ADDR_FILT 4'h6
`define SWK_ADDR_FDCTL 4'h7
`define SWK_ADDR_STAT 4'h8
`define SWK_ADDR_IRQST 4'h9
`define SWK_ADDR_IRQMSK 4'ha
`define SWK_ADDR_TQCUR 4'hb
// Reset values
`define SWK_RST_TQ 8'h0a
`define SWK_RST_SPP 6'h33
`define SWK_RST_LIMHI 8'h0c
`define SWK_RST_LIMLO 8'h08
`define SWK_RST_CLKSEL 2'h0
`define SWK_MODE_OFF 3'h0
// Field positions in FD control register
`define SWK_FD_EN_BIT 0
`define SWK_FD_RXSEL_BIT 1
`define SWK_FD_ERRDIS_BIT 2
`define SWK_FD_FILT_BIT 3
// Field positions in interrupt registers; status register shares bits 0 and 1, bit 2 is FDF skip
`define SWK_ST_SILENT 0
`define SWK_ST_WAKE 1
`define SWK_ST_LIMIT 2
`define SWK_ST_FDF 3
// Timing
`define SWK_CLK_HZ 40000000
`define SWK_SILENCE_MIN_MS 600
`define SWK_IDLE_BITS 4'h8
`define SWK_SYS_PER_TQ 8'h04
`endif

// >>> verilog/swk_pkg.sv
// Types for the selective-wake decoder
package swk_pkg;
  typedef enum logic [1:0] {
    SWK_IDLE = 2'b00,
    SWK_FRAME = 2'b01,
    SWK_SKIP = 2'b10
  } swk_state_t;
endpackage

// >>> testbench/swk_can_node.sv
// CAN node model driving a stuffed random bit stream onto the receive pin
`timescale 1ns/1ps

module swk_can_node (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control from the bench
  input wire logic talk,
  input wire logic [7:0] bitCycles,
  // Bus pin, 1 is recessive
  output logic canRx
);
  logic [7:0] cntQ;
  logic [2:0] runQ;
  logic talkQ;
  logic nextBit;
  integer seed;

  initial seed = 57227;

  // -------------------------------------------------------------
  // Bit generator
  // -------------------------------------------------------------
  // SOF on start of talk, stuff bit after five equal bits
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      canRx <= 1'b1;
      cntQ <= 8'h00;
      runQ <= 3'h0;
      talkQ <= 1'b0;
    end else begin
      talkQ <= talk;
      if (!talk) begin
        canRx <= 1'b1; // Released bus rests recessive
      end else if (!talkQ) begin
        canRx <= 1'b0; // SOF on the first cycle of talk
        cntQ <= 8'h01;
        runQ <= 3'h1;
      end else if (cntQ >= bitCycles) begin // Slow bits
        cntQ <= 8'h01;
        nextBit = 1'($random(seed));
        if (runQ == 3'h5) begin
          canRx <= ~canRx;
          runQ <= 3'h1;
        end else begin
          runQ <= (nextBit == canRx) ? runQ + 3'h1 : 3'h1;
          canRx <= nextBit;
        end
      end else begin
        cntQ <= cntQ + 8'h01;
      end
    end
  end
endmodule

// >>> testbench/can_selective_wake_cdr_setup_bench.sv
// Self-checking bench for the recovery setup and frame tracking block
`timescale 1ns/1ps
`include "swk_cfg.svh"

module can_selective_wake_cdr_setup_bench;
  localparam int SilCyc = 1000;
  logic clk_sys, rstn, read, write, canRx, frameFdf, wakeDetect, talk;
  logic waitrequest, busSilent, wakeOut, irqOut;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [7:0] recoveredTq, tq, bitCycles;
  logic [2:0] transceiverMode;
  logic [1:0] cs;
  integer seed, bad_count, cmp_count;

  swk_cdr_decoder #(.SilenceCycles(SilCyc)) dut (.clk_sys(clk_sys),
    .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .canRx(canRx), .frameFdf(frameFdf), .wakeDetect(wakeDetect),
    .busSilent(busSilent), .wakeOut(wakeOut), .recoveredTq(recoveredTq),
    .transceiverMode(transceiverMode), .irqOut(irqOut));

  swk_can_node node (.clk_sys(clk_sys), .rstn(rstn), .talk(talk),
    .bitCycles(bitCycles), .canRx(canRx));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] idx, input logic rw,
                     input logic [31:0] d);
    int n;
    logic ws;
    n = 0;
    ws = 1'b1;
    address <= {idx, 2'b00};
    writedata <= d;
    read <= ~rw;
    write <= rw;
    // Look mid-cycle, the answer counts at the following rising edge
    while (ws !== 1'b0 && n < 16) begin
      @(negedge clk_sys);
      ws = waitrequest;
      rd = readdata;
      n = n + 1;
      @(posedge clk_sys);
    end
    if (ws !== 1'b0) bad_count = bad_count + 1;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  // Wake pulse; output looked at mid-cycle while it stands
  task automatic pulse_wake(input logic exp);
    wakeDetect <= 1'b1;
    @(posedge clk_sys);
    wakeDetect <= 1'b0;
    @(negedge clk_sys);
    check({31'h0, wakeOut}, {31'h0, exp});
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, wakeOut}, 32'h0);
    @(posedge clk_sys);
  endtask

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    bad_count = bad_count + 1;
    end_sim();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    seed = 57227;
    bad_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    {read, write, frameFdf, wakeDetect, talk} = 5'h00;
    address = 6'h00;
    writedata = 32'h0;
    bitCycles = 8'h28;
    cyc(4);
    rstn <= 1'b1;
    cyc(3);
    check(recoveredTq, 32'h0a);
    rdchk(`SWK_ADDR_SPP, 32'h33);
    rdchk(`SWK_ADDR_TQ, 32'h0a);
    rdchk(`SWK_ADDR_LIMHI, 32'h0c);
    rdchk(`SWK_ADDR_LIMLO, 32'h08);
    wr(4'hc, $random(seed));
    rdchk(4'hc, 32'h0);
    // Setup sequence with traffic on the bus
    tq = 8'h0a + {5'h00, 3'($random(seed))};
    cs = 2'($random(seed));
    bitCycles <= {tq[5:0], 2'b00};
    talk <= 1'b1;
    wr(`SWK_ADDR_MODE, 32'h0);
    check(transceiverMode, 32'h0);
    wr(`SWK_ADDR_CLKSEL, {30'h0, cs});
    wr(`SWK_ADDR_TQ, {24'h0, tq});
    wr(`SWK_ADDR_LIMHI, {24'h0, tq + 8'h02});
    wr(`SWK_ADDR_LIMLO, {24'h0, tq - 8'h02});
    rdchk(`SWK_ADDR_CLKSEL, {30'h0, cs});
    wr(`SWK_ADDR_FILT, 32'h5);
    wr(`SWK_ADDR_MODE, 32'hf);
    check(transceiverMode, 32'h7);
    check(recoveredTq, {24'h0, tq});
    wr(`SWK_ADDR_TQ, {24'h0, tq + 8'h01});
    wr(`SWK_ADDR_LIMHI, 32'h0);
    rdchk(`SWK_ADDR_TQ, {24'h0, tq});
    rdchk(`SWK_ADDR_LIMHI, {24'h0, tq + 8'h02});
    rdchk(`SWK_ADDR_FILT, 32'h5);
    wr(`SWK_ADDR_MODE, 32'h0);
    bus(`SWK_ADDR_IRQST, 1'b0, 32'h0);
    // Silence timeout, error counter disable, masked interrupt
    wr(`SWK_ADDR_FDCTL, 32'h4);
    talk <= 1'b0;
    cyc(600);
    check(busSilent, 32'h0);
    cyc(410);
    check(busSilent, 32'h1);
    check(irqOut, 32'h0);
    rdchk(`SWK_ADDR_FDCTL, 32'h0);
    rdchk(`SWK_ADDR_STAT, 32'h1);
    wr(`SWK_ADDR_IRQMSK, 32'h1);
    cyc(2);
    check(irqOut, 32'h1);
    rdchk(`SWK_ADDR_IRQST, 32'h1);
    cyc(2);
    check(irqOut, 32'h0);
    // Wake pulse and its interrupt
    wr(`SWK_ADDR_IRQMSK, 32'hb);
    pulse_wake(1'b1);
    cyc(2);
    check(irqOut, 32'h1);
    rdchk(`SWK_ADDR_IRQST, 32'h2);
    // FD frame skipped until its end of frame
    wr(`SWK_ADDR_FDCTL, {26'h0, 3'($random(seed)), 3'h1});
    talk <= 1'b1;
    cyc(5 * 4 * tq);
    frameFdf <= 1'b1;
    cyc(1);
    frameFdf <= 1'b0;
    cyc(2);
    rdchk(`SWK_ADDR_STAT, 32'h4);
    pulse_wake(1'b0);
    bus(`SWK_ADDR_IRQST, 1'b0, 32'h0);
    check(rd[3], 32'h1);
    talk <= 1'b0;
    cyc(12 * 4 * tq);
    bus(`SWK_ADDR_STAT, 1'b0, 32'h0);
    check(rd[2], 32'h0);
    pulse_wake(1'b1);
    end_sim();
  end
endmodule
